// file: design/temp_conversion_alarm_ctrl.sv
// Conversion sequencer, limit and slope alarms, with its sample FIFO.
//
// Contract
// - Start on write, pin edge, or free-run.
// - Standby, 8 ms conversion, push, back to standby.
// - Start bit clears itself after measurement.
// - Result is signed 16-bit, 0.005 C per LSB.
// - Pin level powers down when trigger disabled.
// - Trigger enabled: stay powered, selected edge converts.
// - Leaving power-down restores reset values, except the sample FIFO's.
// - Free-run repeats conversion then standby per period.
// - Period code 0 is 64 s, halving, floor 0.125 s.
// - Compare result to limits, set above/below flags.
// - Limits reset to widest codes.
// - Limit flags hold until status read.
// - Limit flags reach interrupt through own enables.
// - Free-run interrupt mode: crossing alerts, read clears.
// - Comparator mode: hysteresis alert, low flag zero.
// - Slope watch needs enable plus free-run or trigger.
// - Slope over last N samples, signed 9 bits.
// - Slope above rise limit or below fall limit flags.
// - Slope flags reach interrupt through own enables.
// - Reading status clears slope flags and, outside comparator mode, interrupt.
// - Window codes give 2,3,5,9,17,33,65,65 samples.
// - Rate limits count 5 mC per sample.
`timescale 1ns/1ps
`default_nettype none

// Sample FIFO with valid/ready on both sides.
module sample_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  initial begin
    if (D < 2 || W < 1) $error("sample_fifo: bad shape");
  end
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  wire           push = in_valid && in_ready;
  wire           pop  = out_valid && out_ready;
  // Full and empty come from the stored count.
  assign in_ready  = (cnt_q != (AW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rp_q];
  // Pointers wrap at the depth.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= (wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1;
      if (pop) rp_q <= (rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  // Storage needs no reset.
  always_ff @(posedge sys_clk) begin
    if (push) mem[wp_q] <= in_data;
  end
endmodule

// Top: register port, conversion sequencer and alarms.
module temp_conversion_alarm_ctrl
  import temp_alarm_pkg::*;
#(
  parameter int CONV_CYC  = CONV_CYCLES,
  parameter int BASE_CYC  = BASE_CYCLES,
  parameter int FIFO_DPTH = FIFO_DEPTH
) (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic [7:0]       reg_rdata_q,
  input  wire logic        convert_powerdown_pin,
  input  wire logic [15:0] adc_result,
  output logic             int_q,
  output logic             powered_down_q,
  output logic             busy_q,
  output logic             sample_valid,
  input  wire logic        sample_ready,
  output logic [15:0]      sample_data
);
  initial begin
    if (CONV_CYC < 1 || BASE_CYC < 1 || FIFO_DPTH < 2) $error("bad parameter");
  end

  conv_state_t  state_q;
  logic [31:0]  conv_cnt_q;
  logic [39:0]  per_cnt_q;
  logic         pin_q;
  logic [15:0]  temp_q;
  logic [15:0]  upper_q;
  logic [15:0]  lower_q;
  logic [7:0]   rise_q;
  logic [7:0]   fall_q;
  logic [7:0]   pin_cfg_q;
  logic [7:0]   grad_cfg_q;
  logic [3:0]   period_q;
  logic [1:0]   convert_q;
  logic [7:0]   ien_q;
  logic [5:2]   stat_q;
  logic [SLOPE_W-1:0] slope_q;
  logic [15:0]  hist [HIST_DEPTH];
  logic [6:0]   hwr_q;
  logic [6:0]   hcnt_q;
  logic         fifo_ready;

  // Mode decode from the configuration registers.
  wire ext_en    = pin_cfg_q[BIT_EXT_EN];
  wire free_run  = convert_q[BIT_FREE];
  wire cmp_mode  = pin_cfg_q[BIT_ALERT] && free_run;
  wire pd        = !ext_en && !convert_powerdown_pin;
  wire grad_on   = grad_cfg_q[BIT_GRAD] && (free_run || ext_en);
  wire wr_hit    = reg_wr && !pd;
  wire rd_status = reg_rd && (reg_addr == ADDR_STATUS);
  wire idle      = (state_q == ST_IDLE);

  // Trigger sources.
  wire rise_edge = convert_powerdown_pin && !pin_q;
  wire fall_edge = !convert_powerdown_pin && pin_q;
  wire pin_trig  = ext_en && (pin_cfg_q[BIT_EDGE] ? rise_edge : fall_edge);
  // Code 0 is 512 base periods; codes above the maximum all give one base period.
  wire [3:0]  per_sh   = (period_q > PERIOD_CODE_MAX) ? 4'h0
                                                      : PERIOD_CODE_MAX + 4'h1 - period_q;
  wire [39:0] per_len  = 40'(BASE_CYC) << per_sh;
  wire per_trig  = free_run && (per_cnt_q == 40'd0);
  wire trig      = convert_q[BIT_START] || pin_trig || per_trig;
  wire conv_done = (state_q == ST_CONV) && (conv_cnt_q == 32'(CONV_CYC - 1));
  wire push_ok   = (state_q == ST_PUSH) && fifo_ready;

  // Slope over the selected window: window minus one is a power of two.
  wire [2:0] win_sh = (grad_cfg_q[2:0] > 3'(WIN_SHIFT_MAX)) ? 3'(WIN_SHIFT_MAX)
                                                           : grad_cfg_q[2:0];
  wire [6:0]  win_m1  = 7'd1 << win_sh;
  wire [6:0]  old_idx = (hwr_q >= win_m1) ? hwr_q - win_m1
                                          : 7'(hwr_q + 7'(HIST_DEPTH) - win_m1);
  wire [15:0] old_smp = hist[old_idx];
  wire signed [16:0] diff = $signed({temp_q[15], temp_q}) - $signed({old_smp[15], old_smp});
  wire signed [16:0] sh   = diff >>> win_sh;
  wire [SLOPE_W-1:0] slope_d = (sh > 17'sd255)  ? 9'h0FF :
                               (sh < -17'sd256) ? 9'h100 : sh[SLOPE_W-1:0];
  wire slope_ok  = grad_on && ((hcnt_q + 7'd1) > win_m1);

  // Flag causes, evaluated in the check cycle.
  wire check     = (state_q == ST_CHECK);
  wire hi_hit    = $signed(temp_q) > $signed(upper_q);
  wire lo_hit    = $signed(temp_q) < $signed(lower_q);
  wire set_above = check && hi_hit;
  wire set_below = check && lo_hit && !cmp_mode;
  wire cmp_clear = check && lo_hit && cmp_mode;
  wire set_rise  = check && slope_ok && ($signed(slope_d) > $signed({1'b0, rise_q}));
  wire set_fall  = check && slope_ok && ($signed(slope_d) < -$signed({1'b0, fall_q}));
  // Set wins over the read-clear; comparator mode ignores reads for the limit flags.
  wire above_d = set_above || (stat_q[BIT_ABOVE] && (cmp_mode ? !cmp_clear : !rd_status));
  wire below_d = !cmp_mode && (set_below || (stat_q[BIT_BELOW] && !rd_status));
  wire rise_d  = set_rise || (stat_q[BIT_RISE] && !rd_status);
  wire fall_d  = set_fall || (stat_q[BIT_FALL] && !rd_status);
  wire [5:2] stat_d = {fall_d, rise_d, below_d, above_d};
  wire int_d = |(stat_d & ien_q[5:2]);

  // Register read multiplexer; unmapped and reserved bits read zero.
  logic [7:0] rd_mux;
  always_comb begin
    case (reg_addr)
      ADDR_STATUS:   rd_mux = {2'b00, stat_q, 2'b00};
      ADDR_IRQ_EN:   rd_mux = ien_q;
      ADDR_PIN_CFG:  rd_mux = pin_cfg_q;
      ADDR_UPPER_HI: rd_mux = upper_q[15:8];
      ADDR_UPPER_LO: rd_mux = upper_q[7:0];
      ADDR_LOWER_HI: rd_mux = lower_q[15:8];
      ADDR_LOWER_LO: rd_mux = lower_q[7:0];
      ADDR_RISE_LIM: rd_mux = rise_q;
      ADDR_FALL_LIM: rd_mux = fall_q;
      ADDR_GRAD_CFG: rd_mux = grad_cfg_q;
      ADDR_PERIOD:   rd_mux = {4'h0, period_q};
      ADDR_CONVERT:  rd_mux = {6'h00, convert_q};
      ADDR_SLOPE_HI: rd_mux = {7'h00, slope_q[8]};
      ADDR_SLOPE_LO: rd_mux = slope_q[7:0];
      default:       rd_mux = 8'h00;
    endcase
  end

  // Host-written configuration; power-down returns it to reset values.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn || pd) begin
      upper_q    <= UPPER_RST;
      lower_q    <= LOWER_RST;
      rise_q     <= RATE_RST;
      fall_q     <= RATE_RST;
      pin_cfg_q  <= 8'h00;
      grad_cfg_q <= 8'h00;
      period_q   <= 4'h0;
      ien_q      <= 8'h00;
    end else if (wr_hit) begin
      if (reg_addr == ADDR_UPPER_HI) upper_q[15:8] <= reg_wdata;
      if (reg_addr == ADDR_UPPER_LO) upper_q[7:0] <= reg_wdata;
      if (reg_addr == ADDR_LOWER_HI) lower_q[15:8] <= reg_wdata;
      if (reg_addr == ADDR_LOWER_LO) lower_q[7:0] <= reg_wdata;
      if (reg_addr == ADDR_RISE_LIM) rise_q <= reg_wdata;
      if (reg_addr == ADDR_FALL_LIM) fall_q <= reg_wdata;
      if (reg_addr == ADDR_PIN_CFG) pin_cfg_q <= reg_wdata;
      if (reg_addr == ADDR_GRAD_CFG) grad_cfg_q <= reg_wdata;
      if (reg_addr == ADDR_PERIOD) period_q <= reg_wdata[3:0];
      if (reg_addr == ADDR_IRQ_EN) ien_q <= reg_wdata;
    end
  end

  // Convert register: start only taken while idle, cleared at push.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn || pd) begin
      convert_q <= 2'b00;
    end else begin
      if (wr_hit && reg_addr == ADDR_CONVERT) convert_q[BIT_FREE] <= reg_wdata[BIT_FREE];
      if (wr_hit && reg_addr == ADDR_CONVERT && idle && reg_wdata[BIT_START]) begin
        convert_q[BIT_START] <= 1'b1;
      end else if (push_ok) begin
        convert_q[BIT_START] <= 1'b0;
      end
    end
  end

  // Conversion sequencer.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn || pd) begin
      state_q    <= ST_IDLE;
      conv_cnt_q <= 32'd0;
      temp_q     <= 16'h0000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          conv_cnt_q <= 32'd0;
          if (trig) state_q <= ST_CONV;
        end
        ST_CONV: begin
          conv_cnt_q <= conv_cnt_q + 32'd1;
          if (conv_done) begin
            temp_q  <= adc_result;
            state_q <= ST_CHECK;
          end
        end
        ST_CHECK: state_q <= ST_PUSH;
        ST_PUSH:  if (fifo_ready) state_q <= ST_IDLE;
        default:  state_q <= ST_IDLE;
      endcase
    end
  end

  // Free-run period counter and pin edge history.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn || pd) begin
      per_cnt_q <= 40'd0;
      pin_q     <= 1'b1;  // Idle level of the pin, so no false edge follows reset.
    end else begin
      pin_q     <= convert_powerdown_pin;
      per_cnt_q <= (!free_run || per_cnt_q == per_len - 40'd1) ? 40'd0 : per_cnt_q + 40'd1;
    end
  end

  // Status flags, slope, interrupt and read data.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn || pd) begin
      stat_q      <= 4'h0;
      slope_q     <= '0;
      int_q       <= 1'b0;
      reg_rdata_q <= 8'h00;
      hwr_q       <= 7'd0;
      hcnt_q      <= 7'd0;
    end else begin
      stat_q      <= stat_d;
      int_q       <= int_d;
      reg_rdata_q <= reg_rd ? rd_mux : 8'h00;
      if (check && slope_ok) slope_q <= slope_d;
      if (check && !grad_on) hcnt_q <= 7'd0;
      if (check && grad_on) begin
        hwr_q  <= (hwr_q == 7'(HIST_DEPTH - 1)) ? 7'd0 : hwr_q + 7'd1;
        hcnt_q <= (hcnt_q == 7'(HIST_DEPTH)) ? hcnt_q : hcnt_q + 7'd1;
      end
    end
  end

  // Sample history for the slope window.
  always_ff @(posedge sys_clk) begin
    if (check && grad_on) hist[hwr_q] <= temp_q;
  end

  // Status outputs.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      powered_down_q <= 1'b0;
      busy_q         <= 1'b0;
    end else begin
      powered_down_q <= pd;
      busy_q         <= !pd && (trig || !idle) && !push_ok;
    end
  end

  sample_fifo #(.W(16), .D(FIFO_DPTH)) u_fifo (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .in_valid  (state_q == ST_PUSH),
    .in_ready  (fifo_ready),
    .in_data   (temp_q),
    .out_valid (sample_valid),
    .out_ready (sample_ready),
    .out_data  (sample_data)
  );

  // Checks on sequencing and alarm behaviour.
  AST_CONV_END: assert property (@(posedge sys_clk) disable iff (!resetn || pd)
    conv_done |=> state_q == ST_CHECK ##1 state_q == ST_PUSH)
    else $error("conversion did not end in check then push");
  AST_CONV_BOUND: assert property (@(posedge sys_clk) disable iff (!resetn)
    state_q == ST_CONV |-> conv_cnt_q < 32'(CONV_CYC))
    else $error("conversion ran past its length");
  AST_START_CLR: assert property (@(posedge sys_clk) disable iff (!resetn || pd)
    push_ok |=> !convert_q[BIT_START] && state_q == ST_IDLE)
    else $error("start bit not cleared after push");
  AST_TRIG_GO: assert property (@(posedge sys_clk) disable iff (!resetn || pd)
    idle && pin_trig |=> state_q == ST_CONV)
    else $error("pin edge did not start a conversion");
  AST_BUSY_IGN: assert property (@(posedge sys_clk) disable iff (!resetn || pd)
    state_q == ST_CONV && !conv_done |=> state_q == ST_CONV && conv_cnt_q == $past(conv_cnt_q) + 32'd1)
    else $error("trigger disturbed a running conversion");
  AST_ABOVE_SET: assert property (@(posedge sys_clk) disable iff (!resetn || pd)
    check && hi_hit |=> stat_q[BIT_ABOVE] ##1 int_q == |(stat_q & ien_q[5:2]))
    else $error("above flag not set on high result");
  AST_FLAG_HOLD: assert property (@(posedge sys_clk) disable iff (!resetn || pd)
    stat_q[BIT_BELOW] && !rd_status && !cmp_mode |=> stat_q[BIT_BELOW])
    else $error("below flag lost without status read");
  AST_IRQ_GATE: assert property (@(posedge sys_clk) disable iff (!resetn)
    int_q == |(stat_q & ien_q[5:2]))
    else $error("interrupt not equal to enabled flags");
  AST_CMP_LOW: assert property (@(posedge sys_clk) disable iff (!resetn)
    cmp_mode && $past(cmp_mode) |-> !stat_q[BIT_BELOW])
    else $error("low flag set in comparator mode");
  AST_PD_RESET: assert property (@(posedge sys_clk) disable iff (!resetn)
    pd |=> upper_q == UPPER_RST && lower_q == LOWER_RST && state_q == ST_IDLE)
    else $error("power-down did not restore reset values");
endmodule
`default_nettype wire

// file: include/temp_alarm_pkg.sv
// Constants shared by the temperature conversion and alarm block.
package temp_alarm_pkg;
  // Register byte addresses.
  localparam logic [7:0] ADDR_STATUS   = 8'h00;
  localparam logic [7:0] ADDR_IRQ_EN   = 8'h02;
  localparam logic [7:0] ADDR_PIN_CFG  = 8'h12;
  localparam logic [7:0] ADDR_UPPER_HI = 8'h22;
  localparam logic [7:0] ADDR_UPPER_LO = 8'h23;
  localparam logic [7:0] ADDR_LOWER_HI = 8'h24;
  localparam logic [7:0] ADDR_LOWER_LO = 8'h25;
  localparam logic [7:0] ADDR_RISE_LIM = 8'h26;
  localparam logic [7:0] ADDR_FALL_LIM = 8'h27;
  localparam logic [7:0] ADDR_GRAD_CFG = 8'h28;
  localparam logic [7:0] ADDR_PERIOD   = 8'h29;
  localparam logic [7:0] ADDR_CONVERT  = 8'h2A;
  localparam logic [7:0] ADDR_SLOPE_HI = 8'h2D;
  localparam logic [7:0] ADDR_SLOPE_LO = 8'h2E;
  // Field positions.
  localparam int BIT_ABOVE  = 2;
  localparam int BIT_BELOW  = 3;
  localparam int BIT_RISE   = 4;
  localparam int BIT_FALL   = 5;
  localparam int BIT_EXT_EN = 7;
  localparam int BIT_EDGE   = 6;
  localparam int BIT_ALERT  = 5;
  localparam int BIT_START  = 0;
  localparam int BIT_FREE   = 1;
  localparam int BIT_GRAD   = 3;
  // Reset values.
  localparam logic [15:0] UPPER_RST = 16'h7FFF;
  localparam logic [15:0] LOWER_RST = 16'h8000;
  localparam logic [7:0]  RATE_RST  = 8'hFF;
  // Timing.
  localparam int CLK_HZ         = 250_000_000;
  localparam int CONV_TIME_MS   = 8;
  localparam int CONV_CYCLES    = CONV_TIME_MS * (CLK_HZ / 1000);
  localparam int BASE_PERIOD_US = 125_000;
  localparam int BASE_CYCLES    = BASE_PERIOD_US * (CLK_HZ / 1_000_000);
  localparam logic [3:0] PERIOD_CODE_MAX = 4'h8;
  // Slope window history and result width.
  localparam int HIST_DEPTH = 65;
  localparam int WIN_SHIFT_MAX = 6;
  localparam int SLOPE_W = 9;
  localparam int FIFO_DEPTH = 16;
  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_CHECK, ST_PUSH} conv_state_t;
endpackage

// file: sim/temp_conversion_alarm_ctrl_tb_top.sv
// Self-checking bench for the conversion, limit and slope alarm block.
`timescale 1ns/1ps
`default_nettype none
module temp_conversion_alarm_ctrl_tb_top;
  import temp_alarm_pkg::*;
  localparam int CONV_T = 20;
  localparam int BASE_T = 50;
  logic        sys_clk;
  logic        resetn;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata_q;
  logic        pin;
  logic [15:0] adc;
  logic        int_q;
  logic        powered_down_q;
  logic        busy_q;
  logic        sample_valid;
  logic        sample_ready;
  logic [15:0] sample_data;
  logic        hold_off;
  logic        rand_stall;
  logic [15:0] pop_count;
  logic [15:0] last_data;
  logic [15:0] base;
  logic [15:0] v;
  logic [7:0]  rd_val;
  logic        busy_seen;
  int          gap;
  int          since;
  int          err_total;
  int          total_checks;
  logic [7:0]  rst_addr [7] = '{8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h40};
  logic [7:0]  rst_exp  [7] = '{8'h7F, 8'hFF, 8'h80, 8'h00, 8'hFF, 8'hFF, 8'h00};
  logic [3:0]  codes    [5] = '{4'h0, 4'h7, 4'h8, 4'h9, 4'hF};

  temp_conversion_alarm_ctrl #(.CONV_CYC(CONV_T), .BASE_CYC(BASE_T), .FIFO_DPTH(16))
    u_temp_conversion_alarm_ctrl (.sys_clk(sys_clk), .resetn(resetn), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .convert_powerdown_pin(pin), .adc_result(adc), .int_q(int_q),
    .powered_down_q(powered_down_q), .busy_q(busy_q), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .sample_data(sample_data));
  temp_host_model u_temp_host_model (.sys_clk(sys_clk), .resetn(resetn),
    .sample_valid(sample_valid), .sample_data(sample_data), .hold_off(hold_off),
    .rand_stall(rand_stall), .sample_ready(sample_ready), .pop_count(pop_count),
    .last_data(last_data));

  // Clock at 250 MHz.
  initial sys_clk = 1'b0;
  always #2 sys_clk = ~sys_clk;

  // Measures the cycles between successive conversion starts.
  always @(posedge sys_clk) begin
    busy_seen <= busy_q;
    since <= (busy_q && !busy_seen) ? 1 : since + 1;
    if (busy_q && !busy_seen) gap <= since;
  end

  // Free-run period in cycles: code 0 is 512 base periods, halving, floor of one.
  function automatic int exp_period(input logic [3:0] code);
    return (code > 4'h8) ? BASE_T : BASE_T << (9 - int'(code));
  endfunction

  // Two-sample slope, saturated to the signed 9-bit slope field.
  function automatic logic [8:0] exp_slope(input logic [15:0] nw, input logic [15:0] od);
    int d;
    d = int'($signed(nw)) - int'($signed(od));
    if (d > 255) d = 255;
    if (d < -256) d = -256;
    return d[8:0];
  endfunction

  task automatic test_done();
    $display("Checks made %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata_q;
  endtask

  // Waits for a conversion to start and end, each under a bound.
  task automatic wait_conv();
    int n;
    for (n = 0; n < 10 && busy_q !== 1'b1; n++) @(posedge sys_clk);
    for (n = 0; n < CONV_T + 40 && busy_q !== 1'b0; n++) @(posedge sys_clk);
    if (busy_q !== 1'b0) begin
      $display("[FAIL] t=%0t conversion wait expired got=%h exp=%h", $time, busy_q, 1'b0);
      err_total++;
      test_done();
    end
    idle(2);
  endtask

  // One single-shot conversion; each starts only after the last ends, a low rate.
  task automatic conv(input logic [15:0] val);
    adc <= val;
    wr(ADDR_CONVERT, 8'h01);
    wait_conv();
  endtask

  // One conversion by a falling edge of the shared pin.
  task automatic pin_conv(input logic [15:0] val);
    adc <= val;
    @(posedge sys_clk);
    pin <= 1'b0;
    wait_conv();
    chk(powered_down_q, 1'b0);
    pin <= 1'b1;
    idle(2);
  endtask

  // Main sequence.
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    pin = 1'b1;
    adc = 16'h0000;
    hold_off = 1'b0;
    rand_stall = 1'b0;
    resetn = 1'b0;
    since = 0;
    gap = 0;
    err_total = 0;
    total_checks = 0;
    void'($urandom(32'hE63D80A4));
    idle(2);
    resetn <= 1'b1;
    foreach (rst_addr[i]) begin
      rd(rst_addr[i], rd_val);
      chk(rd_val, rst_exp[i]);
    end
    chk(int_q, 1'b0);
    $display("test reset_values done");
    for (int i = 0; i < 4; i++) begin
      v = 16'($urandom);
      base = pop_count;
      adc <= v;
      wr(ADDR_CONVERT, 8'h01);
      wr(ADDR_CONVERT, 8'h01);
      wait_conv();
      idle(6);
      chk(pop_count, base + 16'h0001);
      chk(last_data, v);
      rd(ADDR_CONVERT, rd_val);
      chk(rd_val[BIT_START], 1'b0);
    end
    $display("test single_shot done");
    hold_off <= 1'b1;
    base = pop_count;
    for (int i = 0; i < 16; i++) conv(16'($urandom));
    v = 16'h8000;
    adc <= v;
    wr(ADDR_CONVERT, 8'h01);
    idle(CONV_T + 20);
    chk(busy_q, 1'b1);
    chk(sample_valid, 1'b1);
    hold_off <= 1'b0;
    rand_stall <= 1'b1;
    wait_conv();
    for (int n = 0; n < 300 && pop_count !== base + 16'd17; n++) idle(1);
    chk(pop_count, base + 16'd17);
    chk(last_data, v);
    chk(sample_valid, 1'b0);
    rand_stall <= 1'b0;
    $display("test fifo_fill done");
    wr(ADDR_UPPER_HI, 8'h10);
    wr(ADDR_UPPER_LO, 8'h00);
    wr(ADDR_LOWER_HI, 8'hF0);
    wr(ADDR_LOWER_LO, 8'h00);
    wr(ADDR_IRQ_EN, 8'h04);
    rd(ADDR_STATUS, rd_val);
    conv(16'h1000);
    rd(ADDR_STATUS, rd_val);
    chk(rd_val & 8'h3C, 8'h00);
    conv(16'h2000);
    chk(int_q, 1'b1);
    conv(16'h0000);
    chk(int_q, 1'b1);
    rd(ADDR_STATUS, rd_val);
    chk(rd_val & 8'h3C, 8'h04);
    idle(2);
    chk(int_q, 1'b0);
    conv(16'hE000);
    chk(int_q, 1'b0);
    rd(ADDR_STATUS, rd_val);
    chk(rd_val & 8'h3C, 8'h08);
    $display("test limits done");
    foreach (codes[i]) begin
      wr(ADDR_PERIOD, {4'h0, codes[i]});
      wr(ADDR_CONVERT, 8'h02);
      idle(exp_period(codes[i]) + 10);
      chk(16'(gap), 16'(exp_period(codes[i])));
      wr(ADDR_CONVERT, 8'h00);
      idle(CONV_T + 10);
    end
    $display("test free_run done");
    wr(ADDR_PIN_CFG, 8'h00);
    wr(ADDR_UPPER_HI, 8'h12);
    @(posedge sys_clk);
    pin <= 1'b0;
    idle(3);
    chk(powered_down_q, 1'b1);
    wr(ADDR_UPPER_HI, 8'h33);
    pin <= 1'b1;
    idle(3);
    chk(powered_down_q, 1'b0);
    rd(ADDR_UPPER_HI, rd_val);
    chk(rd_val, 8'h7F);
    $display("test power_down done");
    wr(ADDR_RISE_LIM, 8'h04);
    wr(ADDR_FALL_LIM, 8'h04);
    wr(ADDR_IRQ_EN, 8'h30);
    wr(ADDR_GRAD_CFG, 8'h08);
    conv(16'h0000);
    conv(16'h0010);
    rd(ADDR_STATUS, rd_val);
    chk(rd_val & 8'h30, 8'h00);
    wr(ADDR_PIN_CFG, 8'h80);
    base = pop_count;
    pin_conv(16'h0000);
    pin_conv(16'h0010);
    idle(4);
    chk(pop_count, base + 16'h0002);
    chk(int_q, 1'b1);
    rd(ADDR_SLOPE_LO, rd_val);
    chk(rd_val, exp_slope(16'h0010, 16'h0000) & 9'h0FF);
    rd(ADDR_STATUS, rd_val);
    chk(rd_val & 8'h30, 8'h10);
    idle(2);
    chk(int_q, 1'b0);
    pin_conv(16'h0000);
    rd(ADDR_SLOPE_HI, rd_val);
    chk(rd_val[0], exp_slope(16'h0000, 16'h0010) >> 8);
    rd(ADDR_STATUS, rd_val);
    chk(rd_val & 8'h30, 8'h20);
    $display("test slope done");
    wr(ADDR_PIN_CFG, 8'hC0);
    base = pop_count;
    @(posedge sys_clk);
    pin <= 1'b0;
    idle(CONV_T + 10);
    chk(pop_count, base);
    pin <= 1'b1;
    wait_conv();
    idle(6);
    chk(pop_count, base + 16'h0001);
    $display("test rising_edge done");
    wr(ADDR_UPPER_HI, 8'h10);
    wr(ADDR_LOWER_HI, 8'hF0);
    wr(ADDR_IRQ_EN, 8'h04);
    wr(ADDR_PIN_CFG, 8'h20);
    wr(ADDR_PERIOD, 8'h09);
    adc <= 16'h2000;
    wr(ADDR_CONVERT, 8'h02);
    idle(40);
    chk(int_q, 1'b1);
    rd(ADDR_STATUS, rd_val);
    chk(rd_val & 8'h0C, 8'h04);
    idle(2);
    chk(int_q, 1'b1);
    adc <= 16'hE000;
    idle(60);
    chk(int_q, 1'b0);
    rd(ADDR_STATUS, rd_val);
    chk(rd_val & 8'h0C, 8'h00);
    wr(ADDR_CONVERT, 8'h00);
    $display("test comparator done");
    test_done();
  end
endmodule
`default_nettype wire

// file: sim/temp_host_model.sv
// Host-side sample sink that pops the block's FIFO with optional stalls.
`timescale 1ns/1ps
`default_nettype none
module temp_host_model (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        sample_valid,
  input  wire logic [15:0] sample_data,
  input  wire logic        hold_off,
  input  wire logic        rand_stall,
  output logic             sample_ready,
  output logic [15:0]      pop_count,
  output logic [15:0]      last_data
);
  // Ready is withheld fully by hold_off, or at random by rand_stall, as a busy host would.
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sample_ready <= 1'b0;
      pop_count    <= 16'h0000;
      last_data    <= 16'h0000;
    end else begin
      sample_ready <= !hold_off && (!rand_stall || ($urandom % 2 == 0));
      if (sample_valid && sample_ready) begin
        pop_count <= pop_count + 16'h0001;
        last_data <= sample_data;
      end
    end
  end
endmodule
`default_nettype wire
